// *** src/iee_regs.v ***
// Interrupt edge polarity, enable and first request-flag registers
`timescale 1ns/1ps
`include "iee_consts.vh"

module iee_regs (
    // Clock and reset
    input wire clk_in,
    input wire rst_b_in,
    // Avalon-MM slave
    input wire [4:0] avs_address_in,
    input wire avs_read_in,
    input wire avs_write_in,
    input wire [31:0] avs_writedata_in,
    input wire [3:0] avs_byteenable_in,
    output reg [31:0] avs_readdata_out,
    output wire avs_waitrequest_out,
    // Request pins and event inputs
    input wire [3:0] dedicated_request_pin_in,
    input wire [3:0] dedicated_pin_mode_in,
    input wire [7:0] multiplexed_request_pin_in,
    input wire timer_y_event_input_in,
    input wire timer_b_event_input_in,
    input wire conversion_trigger_input_in,
    input wire timer_b1_wrap_in,
    input wire timer_a_wrap_in,
    input wire direct_transfer_req_in,
    input wire converter_done_req_in,
    input wire serial1_done_req_in,
    // Exception logic
    input wire global_mask_in,
    output reg timer_b1_req_out,
    output reg timer_a_req_out,
    output reg [3:0] dedicated_pin_req_out,
    output reg [7:0] multiplexed_pin_req_out,
    output reg direct_transfer_req_out,
    output reg converter_done_req_out,
    output reg serial1_done_req_out,
    output reg interrupt_pending_out,
    // Edge pulses handed to timers and converter
    output reg timer_y_edge_out,
    output reg timer_b_edge_out,
    output reg conversion_trigger_edge_out
);

    // ****************************************************************
    // Helpers
    // ****************************************************************
    // Polarity 1 picks a rising edge, 0 a falling edge, per bit
    function [7:0] iee_edge;
        input [7:0] prev;
        input [7:0] cur;
        input [7:0] pol;
        begin
            iee_edge = (pol & ~prev & cur) | (~pol & prev & ~cur);
        end
    endfunction

    // Write-0-to-clear merge; a set in the same cycle wins
    function [7:0] iee_clear_merge;
        input [7:0] flags;
        input [7:0] wdata;
        input wr;
        begin
            if (wr) begin
                iee_clear_merge = flags & wdata;
            end else begin
                iee_clear_merge = flags;
            end
        end
    endfunction

    // ****************************************************************
    // Registers and state
    // ****************************************************************
    reg [7:0] dedicated_pin_edge_polarity;
    reg [7:0] multiplexed_pin_edge_polarity;
    reg [7:0] timer_and_pin_request_enable;
    reg [7:0] peripheral_request_enable;
    reg [7:0] multiplexed_pin_request_enable;
    reg [7:0] timer_and_pin_request_flags;
    reg [3:0] ded_prev;
    reg [7:0] mux_prev;
    reg [2:0] aux_prev;
    reg prev_valid;
    reg ack;
    reg [7:0] next_flags;
    reg [7:0] rd_byte;
    reg [7:0] flag_set;
    wire req_any;
    wire wr_fire;
    wire wr_lane0;
    wire [7:0] wbyte;
    wire [7:0] ded_edges;
    wire [7:0] mux_edges;
    wire [7:0] aux_edges;
    wire [7:0] aux_pol;

    // ****************************************************************
    // Bus handshake
    // ****************************************************************
    // One wait cycle gives a registered read path and a single write edge
    assign req_any = avs_read_in | avs_write_in;
    assign avs_waitrequest_out = req_any & ~ack;
    assign wr_fire = avs_write_in & ack;
    assign wr_lane0 = wr_fire & avs_byteenable_in[0];
    assign wbyte = avs_writedata_in[7:0];

    always @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ack <= 1'b0;
        end else begin
            ack <= req_any & ~ack;
        end
    end

    // ****************************************************************
    // Edge detection
    // ****************************************************************
    // Nothing is reported until one sample has been taken after reset,
    // so a pin already high at release does not look like a rising edge
    always @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ded_prev <= 4'h0;
            mux_prev <= 8'h00;
            aux_prev <= 3'h0;
            prev_valid <= 1'b0;
        end else begin
            ded_prev <= dedicated_request_pin_in;
            mux_prev <= multiplexed_request_pin_in;
            aux_prev <= {timer_y_event_input_in, timer_b_event_input_in,
                         conversion_trigger_input_in};
            prev_valid <= 1'b1;
        end
    end

    assign ded_edges = iee_edge({4'h0, ded_prev}, {4'h0, dedicated_request_pin_in},
                                dedicated_pin_edge_polarity) & {8{prev_valid}};
    assign mux_edges = iee_edge(mux_prev, multiplexed_request_pin_in,
                                multiplexed_pin_edge_polarity) & {8{prev_valid}};
    // Shared polarity bits steer the timer and trigger inputs too
    assign aux_pol = {5'h00, multiplexed_pin_edge_polarity[`IEE_BIT_TMY],
                      multiplexed_pin_edge_polarity[`IEE_BIT_TMB],
                      multiplexed_pin_edge_polarity[`IEE_BIT_TRG]};
    assign aux_edges = iee_edge({5'h00, aux_prev},
                                {5'h00, timer_y_event_input_in, timer_b_event_input_in,
                                 conversion_trigger_input_in},
                                aux_pol) & {8{prev_valid}};

    // ****************************************************************
    // Flag update
    // ****************************************************************
    always @* begin
        flag_set = 8'h00;
        flag_set[`IEE_BIT_TB1] = timer_b1_wrap_in;
        flag_set[`IEE_BIT_TA] = timer_a_wrap_in;
        flag_set[3:0] = ded_edges[3:0] & dedicated_pin_mode_in;
        // Flags set regardless of the global mask
        next_flags = iee_clear_merge(timer_and_pin_request_flags, wbyte,
                                     wr_lane0 && avs_address_in == `IEE_OFS_TP_FLAGS)
                     | flag_set;
        next_flags = (next_flags & `IEE_WMASK_TP) | `IEE_ONES_TP;
    end

    // ****************************************************************
    // Register writes
    // ****************************************************************
    always @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            dedicated_pin_edge_polarity <= `IEE_RST_DED_POL;
            multiplexed_pin_edge_polarity <= `IEE_RST_MUX_POL;
            timer_and_pin_request_enable <= `IEE_RST_TP_EN;
            peripheral_request_enable <= `IEE_RST_PERI_EN;
            multiplexed_pin_request_enable <= `IEE_RST_MUX_EN;
            timer_and_pin_request_flags <= `IEE_RST_TP_FLAGS;
        end else begin
            timer_and_pin_request_flags <= next_flags;
            if (wr_lane0) begin
                case (avs_address_in)
                    `IEE_OFS_DED_POL: begin
                        dedicated_pin_edge_polarity <= (wbyte & `IEE_WMASK_DED_POL)
                                                       | `IEE_ONES_DED_POL;
                    end
                    `IEE_OFS_MUX_POL: begin
                        multiplexed_pin_edge_polarity <= wbyte;
                    end
                    `IEE_OFS_TP_EN: begin
                        timer_and_pin_request_enable <= (wbyte & `IEE_WMASK_TP)
                                                        | `IEE_ONES_TP;
                    end
                    `IEE_OFS_PERI_EN: begin
                        peripheral_request_enable <= wbyte & `IEE_WMASK_PERI_EN;
                    end
                    `IEE_OFS_MUX_EN: begin
                        multiplexed_pin_request_enable <= wbyte;
                    end
                    default: begin
                        // Unmapped writes and the flag register need nothing here
                    end
                endcase
            end
        end
    end

    // ****************************************************************
    // Read path
    // ****************************************************************
    always @* begin
        case (avs_address_in)
            `IEE_OFS_DED_POL: rd_byte = dedicated_pin_edge_polarity;
            `IEE_OFS_MUX_POL: rd_byte = multiplexed_pin_edge_polarity;
            `IEE_OFS_TP_EN: rd_byte = timer_and_pin_request_enable;
            `IEE_OFS_PERI_EN: rd_byte = peripheral_request_enable;
            `IEE_OFS_MUX_EN: rd_byte = multiplexed_pin_request_enable;
            `IEE_OFS_TP_FLAGS: rd_byte = timer_and_pin_request_flags;
            default: rd_byte = 8'h00;
        endcase
    end

    always @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            avs_readdata_out <= 32'h0000_0000;
        end else if (avs_read_in & ~ack) begin
            avs_readdata_out <= {24'h00_0000, rd_byte};
        end
    end

    // ****************************************************************
    // Requests to the exception logic
    // ****************************************************************
    // Sources whose flags live outside this block are gated directly
    always @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            timer_b1_req_out <= 1'b0;
            timer_a_req_out <= 1'b0;
            dedicated_pin_req_out <= 4'h0;
            multiplexed_pin_req_out <= 8'h00;
            direct_transfer_req_out <= 1'b0;
            converter_done_req_out <= 1'b0;
            serial1_done_req_out <= 1'b0;
            interrupt_pending_out <= 1'b0;
            timer_y_edge_out <= 1'b0;
            timer_b_edge_out <= 1'b0;
            conversion_trigger_edge_out <= 1'b0;
        end else begin
            timer_b1_req_out <= timer_and_pin_request_flags[`IEE_BIT_TB1]
                                & timer_and_pin_request_enable[`IEE_BIT_TB1];
            timer_a_req_out <= timer_and_pin_request_flags[`IEE_BIT_TA]
                               & timer_and_pin_request_enable[`IEE_BIT_TA];
            dedicated_pin_req_out <= timer_and_pin_request_flags[3:0]
                                     & timer_and_pin_request_enable[3:0];
            multiplexed_pin_req_out <= mux_edges & multiplexed_pin_request_enable;
            direct_transfer_req_out <= direct_transfer_req_in
                                       & peripheral_request_enable[`IEE_BIT_DT];
            converter_done_req_out <= converter_done_req_in
                                      & peripheral_request_enable[`IEE_BIT_AD];
            serial1_done_req_out <= serial1_done_req_in
                                    & peripheral_request_enable[`IEE_BIT_S1];
            // Mask only blocks acceptance, never the flags
            interrupt_pending_out <= ~global_mask_in & (timer_b1_req_out | timer_a_req_out
                                     | (|dedicated_pin_req_out) | (|multiplexed_pin_req_out)
                                     | direct_transfer_req_out | converter_done_req_out
                                     | serial1_done_req_out);
            timer_y_edge_out <= aux_edges[2];
            timer_b_edge_out <= aux_edges[1];
            conversion_trigger_edge_out <= aux_edges[0];
        end
    end

endmodule // iee_regs

// *** src/iee_consts.vh ***
// Constants for the interrupt edge, enable and request-flag register block
`ifndef IEE_CONSTS_VH
`define IEE_CONSTS_VH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define IEE_OFS_DED_POL 5'h00
`define IEE_OFS_MUX_POL 5'h04
`define IEE_OFS_TP_EN 5'h08
`define IEE_OFS_PERI_EN 5'h0C
`define IEE_OFS_MUX_EN 5'h10
`define IEE_OFS_TP_FLAGS 5'h14

// ****************************************************************
// Reset values
// ****************************************************************
`define IEE_RST_DED_POL 8'h70
`define IEE_RST_MUX_POL 8'h00
`define IEE_RST_TP_EN 8'h10
`define IEE_RST_PERI_EN 8'h00
`define IEE_RST_MUX_EN 8'h00
`define IEE_RST_TP_FLAGS 8'h10

// ****************************************************************
// Writable-bit masks and forced-one bits
// ****************************************************************
`define IEE_WMASK_DED_POL 8'h0F
`define IEE_ONES_DED_POL 8'h70
`define IEE_WMASK_TP 8'hCF
`define IEE_ONES_TP 8'h10
`define IEE_WMASK_PERI_EN 8'hD0

// ****************************************************************
// Field positions
// ****************************************************************
`define IEE_BIT_TB1 7
`define IEE_BIT_TA 6
`define IEE_BIT_DT 7
`define IEE_BIT_AD 6
`define IEE_BIT_S1 4
`define IEE_BIT_TMY 7
`define IEE_BIT_TMB 6
`define IEE_BIT_TRG 5

// ****************************************************************
// Bus answer timing
// ****************************************************************
`define IEE_WAIT_CYCLES 1

`endif

// *** sim/iee_timer_src.sv ***
// Timer model that raises counter wrap pulses
`timescale 1ns/1ps
module iee_timer_src (
    // Clock and reset
    input wire clk_in,
    input wire rst_b_in,
    // Control and wrap pulses
    input wire run_in,
    output reg timer_b1_wrap_out,
    output reg timer_a_wrap_out
);
    reg [7:0] cnt_a;
    reg [7:0] cnt_b1;
    // Counters start apart so the two wraps never land on one edge
    always @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            cnt_a <= 8'h00;
            cnt_b1 <= 8'h80;
            timer_a_wrap_out <= 1'b0;
            timer_b1_wrap_out <= 1'b0;
        end else begin
            cnt_a <= run_in ? cnt_a + 8'h01 : cnt_a;
            cnt_b1 <= run_in ? cnt_b1 + 8'h01 : cnt_b1;
            timer_a_wrap_out <= run_in && cnt_a == 8'hFF;
            timer_b1_wrap_out <= run_in && cnt_b1 == 8'hFF;
        end
    end
endmodule // iee_timer_src

// *** sim/iee_regs_monitor.sv ***
// Checker for the interrupt edge, enable and flag block
`timescale 1ns/1ps
module iee_regs_monitor (
    // Clock and reset
    input wire clk_in,
    input wire rst_b_in,
    // Sources
    input wire [7:0] multiplexed_request_pin_in,
    input wire timer_y_event_input_in,
    input wire timer_b_event_input_in,
    input wire conversion_trigger_input_in,
    input wire direct_transfer_req_in,
    input wire converter_done_req_in,
    input wire serial1_done_req_in,
    input wire global_mask_in,
    // Requests and edge pulses
    input wire timer_b1_req_out,
    input wire timer_a_req_out,
    input wire [3:0] dedicated_pin_req_out,
    input wire [7:0] multiplexed_pin_req_out,
    input wire direct_transfer_req_out,
    input wire converter_done_req_out,
    input wire serial1_done_req_out,
    input wire interrupt_pending_out,
    input wire timer_y_edge_out,
    input wire timer_b_edge_out,
    input wire conversion_trigger_edge_out
);
    wire any_req = timer_b1_req_out | timer_a_req_out | (|dedicated_pin_req_out)
        | (|multiplexed_pin_req_out) | direct_transfer_req_out | converter_done_req_out
        | serial1_done_req_out;
    wire [7:0] mp = multiplexed_request_pin_in;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);
    a_pending_masked: assert property (interrupt_pending_out == $past(any_req && !global_mask_in))
        else $error("pending does not follow requests and mask");
    a_dt_gated: assert property (direct_transfer_req_out |-> $past(direct_transfer_req_in))
        else $error("direct transfer request without source");
    a_ad_gated: assert property (converter_done_req_out |-> $past(converter_done_req_in))
        else $error("converter request without source");
    a_s1_gated: assert property (serial1_done_req_out |-> $past(serial1_done_req_in))
        else $error("serial request without source");
    a_mux_edge: assert property ((multiplexed_pin_req_out & ~($past(mp) ^ $past(mp, 2))) == 8'h00)
        else $error("pin request without pin edge");
    a_ty_pulse: assert property (timer_y_edge_out |-> $past(timer_y_event_input_in)
        != $past(timer_y_event_input_in, 2) ##1 !timer_y_edge_out)
        else $error("timer y pulse wrong");
    a_y_shared_pol: assert property (multiplexed_pin_req_out[7] && $past(mp[7]) == $past(timer_y_event_input_in)
        && $past(mp[7], 2) == $past(timer_y_event_input_in, 2) |-> timer_y_edge_out)
        else $error("timer y polarity differs from pin 7");
    a_b_shared_pol: assert property (multiplexed_pin_req_out[6] && $past(mp[6]) == $past(timer_b_event_input_in)
        && $past(mp[6], 2) == $past(timer_b_event_input_in, 2) |-> timer_b_edge_out)
        else $error("timer b polarity differs from pin 6");
    a_trg_shared_pol: assert property (multiplexed_pin_req_out[5] && $past(mp[5]) == $past(conversion_trigger_input_in)
        && $past(mp[5], 2) == $past(conversion_trigger_input_in, 2) |-> conversion_trigger_edge_out)
        else $error("trigger polarity differs from pin 5");
endmodule // iee_regs_monitor
bind iee_regs iee_regs_monitor u_mon (.*);

// *** sim/tb_top.sv ***
// Self-checking bench for the interrupt edge, enable and flag block
`timescale 1ns/1ps
module tb_top;
    logic clk_in = 1'b0, rst_b_in = 1'b0, avs_read_in = 1'b0, avs_write_in = 1'b0;
    logic [4:0] avs_address_in = 5'h00;
    logic [31:0] avs_writedata_in = 32'h0000_0000;
    logic [3:0] avs_byteenable_in = 4'h1, dedicated_request_pin_in = 4'h0, dedicated_pin_mode_in = 4'h0;
    logic [7:0] multiplexed_request_pin_in = 8'h00;
    logic timer_y_event_input_in = 1'b0, timer_b_event_input_in = 1'b0, global_mask_in = 1'b0;
    logic conversion_trigger_input_in = 1'b0, direct_transfer_req_in = 1'b0, run = 1'b0;
    logic converter_done_req_in = 1'b0, serial1_done_req_in = 1'b0, clr = 1'b0;
    logic [10:0] seen = 11'h000;
    wire [31:0] avs_readdata_out;
    wire [3:0] dedicated_pin_req_out;
    wire [7:0] multiplexed_pin_req_out;
    wire avs_waitrequest_out, timer_b1_wrap_in, timer_a_wrap_in, timer_b1_req_out, timer_a_req_out;
    wire direct_transfer_req_out, converter_done_req_out, serial1_done_req_out;
    wire interrupt_pending_out, timer_y_edge_out, timer_b_edge_out, conversion_trigger_edge_out;
    int num_errors = 0, n_checks = 0, seed = 77729, cyc = 0;
    logic [7:0] q, p, e;
    logic [31:0] r;
    logic [4:0] offs [6] = '{5'h00, 5'h04, 5'h08, 5'h0C, 5'h10, 5'h14};
    logic [7:0] rv [6] = '{8'h70, 8'h00, 8'h10, 8'h00, 8'h00, 8'h10};

    iee_regs u_dut (.*);
    iee_timer_src u_tmr (.clk_in(clk_in), .rst_b_in(rst_b_in), .run_in(run),
        .timer_b1_wrap_out(timer_b1_wrap_in), .timer_a_wrap_out(timer_a_wrap_in));

    initial forever #2 clk_in = ~clk_in;
    // Edge pulses are short, so they are gathered until cleared
    always @(posedge clk_in) seen <= clr ? 11'h000 : seen | {timer_y_edge_out, timer_b_edge_out,
        conversion_trigger_edge_out, multiplexed_pin_req_out};
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            print_verdict();
        end
    end

    function automatic logic [7:0] wexp(input logic [4:0] a, input logic [7:0] d);
        case (a)
            5'h00: return (d & 8'h0F) | 8'h70;
            5'h08: return (d & 8'hCF) | 8'h10;
            5'h0C: return d & 8'hD0;
            default: return d;
        endcase
    endfunction
    task automatic print_verdict;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Holds the request until waitrequest is sampled low
    task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
        @(posedge clk_in);
        avs_write_in <= w;
        avs_read_in <= !w;
        avs_address_in <= a;
        avs_writedata_in <= {24'h00_0000, d};
        // No local limit: only the cycle ceiling ends a wait that never answers
        do @(posedge clk_in); while (avs_waitrequest_out !== 1'b0);
        q = avs_readdata_out[7:0];
        avs_write_in <= 1'b0;
        avs_read_in <= 1'b0;
    endtask
    task automatic rdc(input logic [4:0] a, input logic [7:0] x);
        bus(1'b0, a, 8'h00);
        chk(q, x);
    endtask
    task automatic mdrv(input logic [7:0] v);
        multiplexed_request_pin_in <= v;
        timer_y_event_input_in <= v[7];
        timer_b_event_input_in <= v[6];
        conversion_trigger_input_in <= v[5];
    endtask

    initial begin
        repeat (10) @(posedge clk_in);
        rst_b_in <= 1'b1;
        for (int i = 0; i < 6; i++) rdc(offs[i], rv[i]);
        rdc(5'h18, 8'h00);
        repeat (6) for (int i = 0; i < 5; i++) begin
            p = $random(seed);
            bus(1'b1, offs[i], p);
            rdc(offs[i], wexp(offs[i], p));
        end
        avs_byteenable_in <= 4'h0;
        bus(1'b1, 5'h10, ~p);
        avs_byteenable_in <= 4'h1;
        rdc(5'h10, p);
        repeat (4) begin
            p = $random(seed);
            dedicated_pin_mode_in <= p[7:4];
            dedicated_request_pin_in <= p[3:0];
            bus(1'b1, 5'h00, p);
            bus(1'b1, 5'h14, 8'h00);
            dedicated_request_pin_in <= ~p[3:0];
            repeat (4) @(posedge clk_in);
            rdc(5'h14, 8'h10);
            dedicated_request_pin_in <= p[3:0];
            repeat (4) @(posedge clk_in);
            rdc(5'h14, {4'h1, p[7:4]});
            e = $random(seed);
            bus(1'b1, 5'h08, e);
            repeat (3) @(posedge clk_in);
            chk(dedicated_pin_req_out, p[7:4] & e[3:0]);
            bus(1'b1, 5'h14, 8'hFF);
            rdc(5'h14, {4'h1, p[7:4]});
            bus(1'b1, 5'h14, 8'h00);
            rdc(5'h14, 8'h10);
        end
        bus(1'b1, 5'h08, 8'hC0);
        global_mask_in <= 1'b1;
        run <= 1'b1;
        repeat (300) @(posedge clk_in);
        run <= 1'b0;
        repeat (4) @(posedge clk_in);
        rdc(5'h14, 8'hD0);
        chk({timer_b1_req_out, timer_a_req_out, interrupt_pending_out}, 3'b110);
        bus(1'b1, 5'h08, 8'h00);
        global_mask_in <= 1'b0;
        repeat (3) @(posedge clk_in);
        chk({timer_b1_req_out, timer_a_req_out}, 2'b00);
        repeat (8) begin
            r = $random(seed);
            {direct_transfer_req_in, converter_done_req_in, serial1_done_req_in} <= r[2:0];
            bus(1'b1, 5'h0C, r[15:8]);
            repeat (3) @(posedge clk_in);
            e = {5'h00, r[15], r[14], r[12]} & {5'h00, r[2:0]};
            chk({direct_transfer_req_out, converter_done_req_out, serial1_done_req_out}, e);
        end
        repeat (4) begin
            p = $random(seed);
            e = $random(seed);
            mdrv(p);
            bus(1'b1, 5'h04, p);
            bus(1'b1, 5'h10, e);
            clr <= 1'b1;
            @(posedge clk_in);
            clr <= 1'b0;
            mdrv(~p);
            repeat (4) @(posedge clk_in);
            chk(seen, 16'h0000);
            mdrv(p);
            repeat (4) @(posedge clk_in);
            chk(seen, {5'h00, 3'b111, e});
        end
        bus(1'b1, 5'h0C, 8'hD0);
        bus(1'b1, 5'h08, 8'hCF);
        repeat (300) begin
            @(posedge clk_in);
            r = $random(seed);
            multiplexed_request_pin_in <= r[7:0];
            timer_y_event_input_in <= r[8] ? r[7] : r[9];
            timer_b_event_input_in <= r[10] ? r[6] : r[11];
            conversion_trigger_input_in <= r[12] ? r[5] : r[13];
            global_mask_in <= r[14];
            dedicated_request_pin_in <= r[19:16];
            {direct_transfer_req_in, converter_done_req_in, serial1_done_req_in} <= r[22:20];
        end
        print_verdict();
    end
endmodule // tb_top
